// ---- pkg/cdt_pkg.sv ----
package cdt_pkg;

  // ==========================================================
  // register map (byte addresses on the register bus)
  localparam logic [7:0] CDT_OFF_CTRL = 8'h00;
  localparam logic [7:0] CDT_OFF_TXDATA = 8'h04;
  localparam logic [7:0] CDT_OFF_RXDATA = 8'h08;
  localparam logic [7:0] CDT_OFF_ENDSTS = 8'h0C;
  localparam logic [7:0] CDT_OFF_STAT = 8'h10;
  localparam logic [7:0] CDT_OFF_THRESH = 8'h14;
  localparam logic [7:0] CDT_OFF_DEVADDR = 8'h18;

  // ==========================================================
  // control field positions
  localparam int CDT_CTRL_DIR_READ = 0;
  localparam int CDT_CTRL_MODE_BURST = 1;
  localparam int CDT_CTRL_FORCE_BURST = 2;
  localparam int CDT_CTRL_START = 3;
  // status byte bit that marks channel end
  localparam int CDT_STS_CHAN_END = 4;

  // ==========================================================
  // reset values
  localparam logic [31:0] CDT_RST_CTRL = 32'h0000_0000;
  localparam logic [7:0] CDT_RST_DEVADDR = 8'h00;

  // ==========================================================
  // timing: control unit share of a connection that marks burst
  localparam int CDT_CLK_MHZ = 25;
  localparam int CDT_BURST_US = 32;
  localparam logic [31:0] CDT_BURST_CYC = 32'(CDT_BURST_US * CDT_CLK_MHZ);

  localparam logic [1:0] CDT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CDT_RESP_DECERR = 2'h3;

  // ==========================================================
  // interface carriers
  typedef struct packed {
    logic op;
    logic sel;
    logic addr;
    logic cmd;
    logic svc;
  } cdt_out_tags_type;

  typedef struct packed {
    logic op;
    logic sts;
    logic svc;
  } cdt_in_tags_type;

  typedef struct packed {
    logic par;
    logic [7:0] data;
  } cdt_bus_type;

  typedef enum logic [2:0] {
    CDT_IDLE = 3'h0,
    CDT_CONN = 3'h1,
    CDT_SVC = 3'h3,
    CDT_SVC_DROP = 3'h2,
    CDT_STS = 3'h6,
    CDT_STS_DROP = 3'h7
  } cdt_state_type;

endpackage

// ---- hw/cdt_ctrl_unit.sv ----
`timescale 1ns/10ps

module cdt_ctrl_unit (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // selection logic: connection obtained
  input wire logic sel_done,
  // channel side
  input wire cdt_pkg::cdt_out_tags_type out_tags,
  input wire cdt_pkg::cdt_bus_type bus_out,
  output cdt_pkg::cdt_in_tags_type in_tags,
  output cdt_pkg::cdt_bus_type bus_in
);
  import cdt_pkg::*;

  cdt_state_type state_reg, state_next;
  logic dir_read_reg, mode_sw_reg, force_cfg_reg, force_reg;
  logic op_active_reg, stopped_reg, stacked_reg, burst_reg;
  logic tx_pend_reg, rx_valid_reg, sts_pend_reg;
  logic [7:0] tx_data_reg, rx_data_reg, sts_byte_reg, dev_addr_reg;
  logic [31:0] thresh_reg, conn_cnt_reg;
  cdt_bus_type bus_in_reg;
  logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic op_in, tags_quiet, disc, want_data, hold_conn;
  logic wr_fire, rd_fire, rd_rx;

  // ==========================================================
  // channel tag decode
  assign tags_quiet = !out_tags.svc && !out_tags.cmd;
  // address out with hold dropped while connected is a disconnect
  assign disc = out_tags.addr && !out_tags.sel && state_reg != CDT_IDLE;
  // direction comes from the accepted command type
  assign want_data = dir_read_reg ? tx_pend_reg : !rx_valid_reg;
  // switch only counts once the channel lets go of hold out
  assign hold_conn = force_reg || (mode_sw_reg && op_active_reg);
  assign op_in = state_reg != CDT_IDLE && out_tags.op;

  // ==========================================================
  // connection sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CDT_IDLE: begin
        if (sel_done && out_tags.op) begin
          state_next = CDT_CONN;
        end
      end
      CDT_CONN: begin
        if (tags_quiet && sts_pend_reg) begin
          state_next = CDT_STS;
        end else if (tags_quiet && op_active_reg && !stopped_reg &&
                     want_data) begin
          state_next = CDT_SVC;
        end else if (!out_tags.sel && !hold_conn) begin
          state_next = CDT_IDLE;
        end
      end
      CDT_SVC: begin
        if (out_tags.svc || out_tags.cmd) begin
          state_next = CDT_SVC_DROP;
        end
      end
      CDT_SVC_DROP: begin
        if (tags_quiet) begin
          state_next = CDT_CONN;
        end
      end
      CDT_STS: begin
        if (out_tags.svc || out_tags.cmd) begin
          state_next = CDT_STS_DROP;
        end
      end
      CDT_STS_DROP: begin
        if (tags_quiet) begin
          state_next = CDT_CONN;
        end
      end
      default: state_next = CDT_IDLE;
    endcase
    if (!out_tags.op || disc) begin
      state_next = CDT_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= CDT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // inbound bus: loaded as an in tag is about to rise, so the
  // byte is stable the whole time the tag is up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_in_reg <= '0;
    end else if (state_reg == CDT_CONN && state_next == CDT_STS) begin
      bus_in_reg <= '{par: ~^sts_byte_reg, data: sts_byte_reg};
    end else if (state_reg == CDT_CONN && state_next == CDT_SVC) begin
      bus_in_reg.data <= dir_read_reg ? tx_data_reg : 8'h00;
      bus_in_reg.par <= dir_read_reg ? ~^tx_data_reg : 1'b1;
    end
  end

  // ==========================================================
  // operation state, stop and stacking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_active_reg <= 1'b0;
      stopped_reg <= 1'b0;
      stacked_reg <= 1'b0;
    end else begin
      if (wr_fire && aw_addr_reg == CDT_OFF_CTRL &&
          w_data_reg[CDT_CTRL_START]) begin
        op_active_reg <= 1'b1;
        stopped_reg <= 1'b0;
      end
      if (state_reg == CDT_SVC && out_tags.cmd) begin
        stopped_reg <= 1'b1;
      end
      if (state_reg == CDT_STS && out_tags.cmd) begin
        stacked_reg <= 1'b1;
      end else if (state_reg == CDT_STS && out_tags.svc) begin
        stacked_reg <= 1'b0;
        if (sts_byte_reg[CDT_STS_CHAN_END]) begin
          op_active_reg <= 1'b0;
        end
      end
    end
  end

  // force burst holds operational in for the whole operation,
  // but a channel disconnect overrides it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_reg <= 1'b0;
    end else if (disc || !op_active_reg) begin
      force_reg <= 1'b0;
    end else if (state_reg == CDT_IDLE && sel_done && force_cfg_reg) begin
      force_reg <= 1'b1;
    end
  end

  // ==========================================================
  // connection timer and mode classification
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conn_cnt_reg <= '0;
      burst_reg <= 1'b0;
    end else if (state_reg == CDT_IDLE) begin
      conn_cnt_reg <= '0;
      if (state_next != CDT_IDLE) begin
        burst_reg <= 1'b0;
      end
    end else if (op_in) begin
      if (conn_cnt_reg != '1) begin
        conn_cnt_reg <= conn_cnt_reg + 32'h0000_0001;
      end
      if (conn_cnt_reg > thresh_reg) begin
        burst_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // data and status holding; hardware set wins over software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid_reg <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (state_reg == CDT_SVC && out_tags.svc && !dir_read_reg) begin
      rx_valid_reg <= 1'b1;
      rx_data_reg <= bus_out.data;
    end else if (rd_rx) begin
      rx_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_pend_reg <= 1'b0;
      tx_data_reg <= 8'h00;
    end else if (wr_fire && aw_addr_reg == CDT_OFF_TXDATA) begin
      tx_pend_reg <= 1'b1;
      tx_data_reg <= w_data_reg[7:0];
    end else if (state_reg == CDT_SVC && dir_read_reg &&
                 (out_tags.svc || out_tags.cmd)) begin
      // a stop drops the byte so it cannot leak into a later operation
      tx_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_pend_reg <= 1'b0;
      sts_byte_reg <= 8'h00;
    end else if (wr_fire && aw_addr_reg == CDT_OFF_ENDSTS) begin
      sts_pend_reg <= 1'b1;
      sts_byte_reg <= w_data_reg[7:0];
    end else if (state_reg == CDT_STS && (out_tags.svc || out_tags.cmd)) begin
      sts_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_read_reg <= CDT_RST_CTRL[CDT_CTRL_DIR_READ];
      mode_sw_reg <= CDT_RST_CTRL[CDT_CTRL_MODE_BURST];
      force_cfg_reg <= CDT_RST_CTRL[CDT_CTRL_FORCE_BURST];
      thresh_reg <= CDT_BURST_CYC;
      dev_addr_reg <= CDT_RST_DEVADDR;
    end else if (wr_fire) begin
      // direction may not change in the middle of a transfer
      if (aw_addr_reg == CDT_OFF_CTRL && state_reg == CDT_IDLE) begin
        dir_read_reg <= w_data_reg[CDT_CTRL_DIR_READ];
        mode_sw_reg <= w_data_reg[CDT_CTRL_MODE_BURST];
        force_cfg_reg <= w_data_reg[CDT_CTRL_FORCE_BURST];
      end
      if (aw_addr_reg == CDT_OFF_THRESH) begin
        thresh_reg <= w_data_reg;
      end
      if (aw_addr_reg == CDT_OFF_DEVADDR) begin
        dev_addr_reg <= w_data_reg[7:0];
      end
    end
  end

  // ==========================================================
  // register bus slave: address and data taken in either order
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign rd_fire = s_axi_arvalid && !rvalid_reg;
  assign rd_rx = rd_fire && s_axi_araddr == CDT_OFF_RXDATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      bresp_reg <= CDT_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= (aw_addr_reg > CDT_OFF_DEVADDR ||
                      aw_addr_reg[1:0] != 2'h0 ||
                      aw_addr_reg == CDT_OFF_RXDATA ||
                      aw_addr_reg == CDT_OFF_STAT) ?
                     CDT_RESP_DECERR : CDT_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= CDT_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= CDT_RESP_OKAY;
      case (s_axi_araddr)
        CDT_OFF_CTRL: rdata_reg <= {28'h000_0000, op_active_reg,
          force_cfg_reg, mode_sw_reg, dir_read_reg};
        CDT_OFF_TXDATA: rdata_reg <= {24'h00_0000, tx_data_reg};
        CDT_OFF_RXDATA: rdata_reg <= {24'h00_0000, rx_data_reg};
        CDT_OFF_ENDSTS: rdata_reg <= {24'h00_0000, sts_byte_reg};
        CDT_OFF_STAT: rdata_reg <= {22'h00_0000, state_reg, force_reg,
          burst_reg, stacked_reg, stopped_reg, sts_pend_reg,
          rx_valid_reg, tx_pend_reg};
        CDT_OFF_THRESH: rdata_reg <= thresh_reg;
        CDT_OFF_DEVADDR: rdata_reg <= {23'h00_0000, ~^dev_addr_reg,
          dev_addr_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= CDT_RESP_DECERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ==========================================================
  // channel outputs
  assign in_tags = '{op: op_in,
                     sts: state_reg == CDT_STS && out_tags.op,
                     svc: state_reg == CDT_SVC && out_tags.op};
  assign bus_in = bus_in_reg;

  // ==========================================================
  // checks
  a_svc_held: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.svc && tags_quiet && out_tags.op && !disc |=> in_tags.svc)
    else $error("service in dropped before answer");
  a_bus_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.svc && $past(in_tags.svc) |-> $stable(bus_in))
    else $error("inbound bus changed under service in");
  a_rx_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.svc && out_tags.svc && !dir_read_reg
    |=> rx_valid_reg && rx_data_reg == $past(bus_out.data))
    else $error("outbound byte not captured");
  a_op_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(out_tags.op) |=> state_reg == CDT_IDLE && !in_tags.op)
    else $error("operational in outlived operational out");
  a_no_early_disc: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.op && out_tags.sel ##1 (out_tags.op && !disc)
    |-> in_tags.op)
    else $error("disconnect while hold out up");
  a_force_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.op && force_reg && !disc ##1 (out_tags.op && !disc)
    |-> in_tags.op)
    else $error("forced burst connection dropped");
  a_disc_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    disc |=> !force_reg && !in_tags.op)
    else $error("disconnect did not clear force burst");
  a_stop_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.svc && out_tags.cmd |=> !in_tags.svc [*2])
    else $error("service in after stop");
  a_sts_first: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == CDT_CONN && sts_pend_reg && tags_quiet && out_tags.op &&
    !disc |=> in_tags.sts && bus_in.data == $past(sts_byte_reg))
    else $error("pending status not presented");
  a_burst_mark: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.op && conn_cnt_reg > thresh_reg && state_reg != CDT_IDLE
    |=> burst_reg)
    else $error("long connection not marked burst");
  a_sts_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.sts && out_tags.svc |=> !in_tags.sts && !sts_pend_reg)
    else $error("accepted status not retired");
  a_bus_parity: assert property (@(posedge aclk) disable iff (!aresetn)
    in_tags.svc || in_tags.sts |-> ^bus_in)
    else $error("inbound bus parity not odd");

endmodule // cdt_ctrl_unit

// ---- verif/cdt_chan_model.sv ----
`timescale 1ns/10ps

// ==========================================================
// channel model: answers in-tags after a programmable delay
module cdt_chan_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control unit side
  input wire cdt_pkg::cdt_in_tags_type in_tags,
  input wire cdt_pkg::cdt_bus_type bus_in,
  // scenario controls
  input wire logic op_en,
  input wire logic sel_en,
  input wire logic disc,
  input wire logic stop_mode,
  input wire logic stack_mode,
  input wire logic [3:0] delay,
  input wire logic [7:0] out_byte,
  // channel outputs and capture
  output cdt_pkg::cdt_out_tags_type out_tags,
  output cdt_pkg::cdt_bus_type bus_out,
  output logic [7:0] got_byte,
  output logic [7:0] sts_byte,
  output logic [7:0] got_cnt
);
  import cdt_pkg::*;
  logic [3:0] wait_cnt;
  logic rsp_svc;
  logic rsp_cmd;

  assign out_tags = {op_en, sel_en, disc, rsp_cmd, rsp_svc};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_svc <= 1'h0;
      rsp_cmd <= 1'h0;
      wait_cnt <= 4'h0;
      got_cnt <= 8'h00;
      got_byte <= 8'h00;
      sts_byte <= 8'h00;
      bus_out <= 9'h0AA;
    end else if (rsp_svc || rsp_cmd) begin
      // out-tag falls only once the in-tag has fallen
      if (!in_tags.svc && !in_tags.sts) begin
        rsp_svc <= 1'h0;
        rsp_cmd <= 1'h0;
        bus_out <= ~bus_out;
      end
    end else if (in_tags.svc || in_tags.sts) begin
      if (wait_cnt < delay) begin
        wait_cnt <= wait_cnt + 4'h1;
      end else begin
        wait_cnt <= 4'h0;
        if (in_tags.sts) begin
          sts_byte <= bus_in.data;
          rsp_cmd <= stack_mode;
          rsp_svc <= !stack_mode;
        end else if (stop_mode) begin
          rsp_cmd <= 1'h1;
        end else begin
          rsp_svc <= 1'h1;
          got_byte <= bus_in.data;
          got_cnt <= got_cnt + 8'h01;
          bus_out <= {~^out_byte, out_byte};
        end
      end
    end else begin
      // no gap time-out here: long burst idles are tolerated
      // released bus must not look like the last byte
      bus_out <= ~bus_out;
    end
  end
endmodule // cdt_chan_model

// ---- verif/cdt_ctrl_unit_tb.sv ----
`timescale 1ns/10ps

module cdt_ctrl_unit_tb;
  import cdt_pkg::*;
  // ==========================================================
  // signals
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic sel_done = 1'h0;
  logic op_en = 1'h1;
  logic sel_en = 1'h0;
  logic disc = 1'h0;
  logic stop_mode = 1'h0;
  logic stack_mode = 1'h0;
  logic [3:0] delay = 4'h0;
  logic [7:0] out_byte = 8'h00;
  cdt_out_tags_type out_tags;
  cdt_in_tags_type in_tags;
  cdt_bus_type bus_out, bus_in;
  logic [7:0] got_byte, sts_byte, got_cnt, n0;
  logic [31:0] rd_val;
  logic [1:0] rd_rsp;
  int checks = 0;
  int bad_count = 0;
  int cycles = 0;

  always #20 aclk = ~aclk;

  cdt_ctrl_unit dut_u (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sel_done, .out_tags, .bus_out,
    .in_tags, .bus_in
  );

  cdt_chan_model chan_u (
    .aclk, .aresetn, .in_tags, .bus_in, .op_en, .sel_en, .disc,
    .stop_mode, .stack_mode, .delay, .out_byte, .out_tags, .bus_out,
    .got_byte, .sts_byte, .got_cnt
  );

  // ==========================================================
  // reporting
  task automatic conclude();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // generous ceiling: the whole sequence needs a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ==========================================================
  // register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    while (s_axi_bvalid !== 1'h1) @(posedge aclk);
    check("bresp", 32'(s_axi_bresp), 32'(e));
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    rd_val = s_axi_rdata;
    rd_rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
    rd(a);
    check(nm, rd_val & m, e);
  endtask

  // ==========================================================
  // link helpers
  task automatic connect();
    sel_en <= 1'h1;
    sel_done <= 1'h1;
    @(posedge aclk);
    sel_done <= 1'h0;
    @(posedge aclk);
    check("op_in up", 32'(in_tags.op), 32'h1);
  endtask

  task automatic hold_chk(input int n);
    logic ok;
    ok = 1'h1;
    repeat (n) begin
      @(posedge aclk);
      if (in_tags.op !== 1'h1) ok = 1'h0;
    end
    check("op_in held", 32'(ok), 32'h1);
  endtask

  task automatic wait_byte();
    n0 = got_cnt;
    while (got_cnt === n0) @(posedge aclk);
  endtask

  task automatic wait_drop();
    while (in_tags.op !== 1'h0) @(posedge aclk);
  endtask

  // ==========================================================
  // sequence
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdc(CDT_OFF_CTRL, 32'hFFFF_FFFF, CDT_RST_CTRL, "ctrl");
    rdc(CDT_OFF_THRESH, 32'hFFFF_FFFF, CDT_BURST_CYC, "thresh");
    rdc(CDT_OFF_DEVADDR, 32'h0000_01FF,
        {23'h0, ~^CDT_RST_DEVADDR, CDT_RST_DEVADDR}, "devaddr");
    rd(8'h1C);
    check("unmapped rresp", 32'(rd_rsp), 32'(CDT_RESP_DECERR));
    wr(CDT_OFF_STAT, 32'h0000_0000, CDT_RESP_DECERR);
    wr(CDT_OFF_DEVADDR, 32'h0000_00A5, CDT_RESP_OKAY);
    rdc(CDT_OFF_DEVADDR, 32'h0000_01FF, 32'h0000_01A5, "par");
    wr(CDT_OFF_THRESH, 32'h0000_000A, CDT_RESP_OKAY);
    rdc(CDT_OFF_THRESH, 32'hFFFF_FFFF, 32'h0000_000A, "thr");
    // inbound bytes to a slow channel, mode switch set to burst
    delay <= 4'h5;
    wr(CDT_OFF_CTRL, 32'h0000_000B, CDT_RESP_OKAY);
    connect();
    wr(CDT_OFF_TXDATA, 32'h0000_003C, CDT_RESP_OKAY);
    wait_byte();
    check("byte 1", 32'(got_byte), 32'h0000_003C);
    wr(CDT_OFF_TXDATA, 32'h0000_00C3, CDT_RESP_OKAY);
    wait_byte();
    check("byte 2", 32'(got_byte), 32'h0000_00C3);
    rdc(CDT_OFF_STAT, 32'h0000_0001, 32'h0000_0000, "tx_pend");
    sel_en <= 1'h0;
    hold_chk(20);
    // channel ends first: stop, then ending status
    stop_mode <= 1'h1;
    delay <= 4'h0;
    n0 = got_cnt;
    wr(CDT_OFF_TXDATA, 32'h0000_0055, CDT_RESP_OKAY);
    repeat (10) @(posedge aclk);
    rdc(CDT_OFF_STAT, 32'h0000_0009, 32'h0000_0008, "stopped");
    check("no byte", 32'(got_cnt), 32'(n0));
    wr(CDT_OFF_ENDSTS, 32'h0000_0010, CDT_RESP_OKAY);
    wait_drop();
    check("end status", 32'(sts_byte), 32'h0000_0010);
    rdc(CDT_OFF_STAT, 32'h0000_0394, 32'h0000_0000, "idle");
    rdc(CDT_OFF_CTRL, 32'h0000_0008, 32'h0000_0000, "op end");
    stop_mode <= 1'h0;
    // outbound bytes with forced burst, then interface disconnect
    delay <= 4'h2;
    out_byte <= 8'h96;
    wr(CDT_OFF_CTRL, 32'h0000_000C, CDT_RESP_OKAY);
    connect();
    wait_byte();
    repeat (4) @(posedge aclk);
    rdc(CDT_OFF_RXDATA, 32'h0000_00FF, 32'h0000_0096, "rx");
    sel_en <= 1'h0;
    hold_chk(20);
    rdc(CDT_OFF_STAT, 32'h0000_0060, 32'h0000_0060, "burst");
    disc <= 1'h1;
    wait_drop();
    disc <= 1'h0;
    rdc(CDT_OFF_STAT, 32'h0000_03C0, 32'h0000_0000, "no force");
    // unsolicited status, stacked by the channel
    stack_mode <= 1'h1;
    wr(CDT_OFF_CTRL, 32'h0000_0001, CDT_RESP_OKAY);
    n0 = got_cnt;
    connect();
    wr(CDT_OFF_ENDSTS, 32'h0000_0080, CDT_RESP_OKAY);
    repeat (10) @(posedge aclk);
    check("attn", 32'(sts_byte), 32'h0000_0080);
    check("no stale byte", 32'(got_cnt), 32'(n0));
    rdc(CDT_OFF_STAT, 32'h0000_0014, 32'h0000_0010, "stacked");
    op_en <= 1'h0;
    @(posedge aclk);
    #1;
    check("op_in gated", 32'(in_tags.op), 32'h0);
    @(posedge aclk);
    @(posedge aclk);
    rdc(CDT_OFF_STAT, 32'h0000_0380, 32'h0000_0000, "op out idle");
    conclude();
  end
endmodule // cdt_ctrl_unit_tb
